// ===== src/est_pkg.sv
// Shared constants and types for the event state timer and PWM unit.
package est_pkg;
  // ==========================================================
  // Sizes
  localparam int EST_N_IN = 8;
  localparam int EST_N_OUT = 10;
  localparam int EST_N_MR = 16;
  localparam int EST_N_EV = 16;
  localparam int EST_SW = 5;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] EST_CFG_OFS = 12'h000;
  localparam logic [11:0] EST_CTL_OFS = 12'h004;
  localparam logic [11:0] EST_CNT_OFS = 12'h008;
  localparam logic [11:0] EST_STA_OFS = 12'h00c;
  localparam logic [11:0] EST_INP_OFS = 12'h010;
  localparam logic [11:0] EST_OUT_OFS = 12'h014;
  localparam logic [11:0] EST_FLG_OFS = 12'h018;
  localparam logic [11:0] EST_IEN_OFS = 12'h01c;
  localparam logic [11:0] EST_RMD_OFS = 12'h020;
  localparam logic [11:0] EST_CFL_OFS = 12'h024;
  localparam logic [3:0] EST_EV_PAGE = 4'h1;
  localparam logic [3:0] EST_MR_PAGE = 4'h2;
  // ==========================================================
  // Field positions
  localparam int EST_CFG_UNIFY = 0;
  localparam int EST_CFG_CLKIN = 1;
  localparam int EST_CFG_ISEL = 2;
  localparam int EST_CFG_ALIM = 5;
  localparam int EST_CTL_DOWN = 0;
  localparam int EST_CTL_STOP = 1;
  localparam int EST_CTL_HALT = 2;
  localparam int EST_CTL_BIDIR = 3;
  localparam int EST_CTL_CLR = 4;
  localparam int EST_CTL_HI = 16;
  localparam int EST_EVC_MSEL = 0;
  localparam int EST_EVC_HIGH = 4;
  localparam int EST_EVC_IOOUT = 5;
  localparam int EST_EVC_IOSEL = 6;
  localparam int EST_EVC_IOCND = 10;
  localparam int EST_EVC_COMB = 12;
  localparam int EST_EVC_STLD = 14;
  localparam int EST_EVC_STV = 15;
  localparam int EST_EVC_MHOLD = 20;
  localparam int EST_EVC_DIRQ = 21;
  localparam int EST_EVO_CLR = 16;
  localparam int EST_EVA_LIM = 16;
  localparam int EST_EVA_STOP = 17;
  localparam int EST_EVA_START = 18;
  localparam int EST_EVA_HALT = 19;
  localparam int EST_EVA_DMA = 20;
  // ==========================================================
  // Reset values
  localparam logic [31:0] EST_CTL_RST = 32'h0002_0002;
  localparam logic [31:0] EST_ZERO_RST = 32'h0000_0000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    EST_COMB_OR = 2'h0,
    EST_COMB_MATCH = 2'h1,
    EST_COMB_IO = 2'h2,
    EST_COMB_AND = 2'h3
  } est_comb_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } est_av_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } est_av_rsp_s;
endpackage

// ===== src/est_core.sv
// Event state timer and PWM unit with an Avalon-MM register slave.
// Notes on behaviour
// - Counter runs as one 32-bit counter or two 16-bit halves with own control.
// - Counters advance on every clock or on rising edges of a selected input.
// - Sixteen registers, each a match comparator or a capture register.
// - Event built from match, input/output edge or level, or both together.
// - Events can start, stop, halt, limit a counter or reverse its direction.
// - Events cause state changes, output changes, interrupts and DMA requests.
// - Match register zero can limit the counter without any event.
// - In bidirectional mode an event can be restricted to one count direction.
// - A match can be held pending until the input/output condition comes.
// - Each event has a state mask; it occurs only in enabled states.
// - An event loads a configured next state into the state variable.
// - The state variable survives counter wrap and limit.
// - Match or input/output triggered events copy the count into capture registers.
// - Any event can force the count into any capture register.
// - Up to ten single-edge or seven dual-edge PWM outputs share one period.
// - Limit clears the counter one-way, reverses it in bidirectional mode.
// - An event can set, clear or toggle any output.
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module est_core (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input est_pkg::est_av_req_s av_req_i,
  output est_pkg::est_av_rsp_s av_rsp_o,
  input wire logic [est_pkg::EST_N_IN-1:0] ev_in_i,
  output logic [est_pkg::EST_N_OUT-1:0] ev_out_o,
  output logic irq_o,
  output logic dma_req_o
);
  import est_pkg::*;

  // ==========================================================
  // Storage
  logic [31:0] cfg_q, ctl_q, cnt_q, flag_q, ien_q, rmd_q, cfl_q;
  logic [EST_SW-1:0] st_q [2];
  logic [31:0] mr_q [EST_N_MR];
  logic [31:0] evs_q [EST_N_EV];
  logic [31:0] evc_q [EST_N_EV];
  logic [31:0] evo_q [EST_N_EV];
  logic [31:0] eva_q [EST_N_EV];
  logic [EST_N_IN-1:0] in_prev_q;
  logic [EST_N_OUT-1:0] out_q, out_prev_q;
  logic [EST_N_EV-1:0] mpend_q;
  est_av_rsp_s rsp_q;
  logic irq_q, dma_q;

  assign av_rsp_o = rsp_q;
  assign ev_out_o = out_q;
  assign irq_o = irq_q;
  assign dma_req_o = dma_q;

  // ==========================================================
  // Bus decode
  logic acc, wr_acc;
  logic [11:0] adr;
  logic is_ev, is_mr;
  logic [3:0] ev_idx, mr_idx;
  logic [1:0] ev_sub;
  logic [31:0] bmask, wdat;

  assign adr = av_req_i.address;
  // A request is taken at the edge where waitrequest is seen low.
  assign acc = (av_req_i.read | av_req_i.write) & ~rsp_q.waitrequest;
  assign wr_acc = acc & av_req_i.write;
  assign is_ev = adr[11:8] == EST_EV_PAGE;
  assign is_mr = (adr[11:8] == EST_MR_PAGE) && (adr[7:6] == 2'h0);
  assign ev_idx = adr[7:4];
  assign ev_sub = adr[3:2];
  assign mr_idx = adr[5:2];
  assign bmask = {{8{av_req_i.byteenable[3]}}, {8{av_req_i.byteenable[2]}},
                  {8{av_req_i.byteenable[1]}}, {8{av_req_i.byteenable[0]}}};
  assign wdat = av_req_i.writedata;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic wr_hit(input logic [11:0] ofs);
    wr_hit = wr_acc && (adr == ofs);
  endfunction

  // ==========================================================
  // Counter clocking and matches
  logic unify, tick;
  logic [2:0] isel;
  logic [1:0] run, dir, bidir, adv;
  logic [EST_N_MR-1:0] hit_lo, hit_hi;
  logic [15:0] in16, inp16, out16, outp16;

  assign unify = cfg_q[EST_CFG_UNIFY];
  assign isel = cfg_q[EST_CFG_ISEL +: 3];
  // Input clocking counts rising edges seen in core clock cycles.
  assign tick = ~cfg_q[EST_CFG_CLKIN]
                | (ev_in_i[isel] & ~in_prev_q[isel]);
  assign in16 = {{(16-EST_N_IN){1'b0}}, ev_in_i};
  assign inp16 = {{(16-EST_N_IN){1'b0}}, in_prev_q};
  assign out16 = {{(16-EST_N_OUT){1'b0}}, out_q};
  assign outp16 = {{(16-EST_N_OUT){1'b0}}, out_prev_q};

  always_comb begin
    for (int h = 0; h < 2; h++) begin
      run[h] = ~ctl_q[h*EST_CTL_HI + EST_CTL_STOP]
               & ~ctl_q[h*EST_CTL_HI + EST_CTL_HALT];
      bidir[h] = ctl_q[h*EST_CTL_HI + EST_CTL_BIDIR];
      dir[h] = ctl_q[h*EST_CTL_HI + EST_CTL_DOWN] & bidir[h];
      adv[h] = run[h] & tick;
    end
    for (int j = 0; j < EST_N_MR; j++) begin
      // Capture-mode registers never produce matches.
      hit_lo[j] = ~rmd_q[j] & (unify ? (cnt_q == mr_q[j])
                                     : (cnt_q[15:0] == mr_q[j][15:0]));
      hit_hi[j] = ~rmd_q[j] & (cnt_q[31:16] == mr_q[j][31:16]);
    end
  end

  // ==========================================================
  // Event evaluation
  logic [EST_N_EV-1:0] ev, ev_mt;
  logic [1:0] lim, stp, sta, hlt, ld;
  logic [EST_SW-1:0] st_nx [2];
  logic [EST_N_OUT-1:0] o_set, o_clr;
  logic [EST_N_MR-1:0] cap_lo, cap_hi;
  logic dma_any;

  always_comb begin
    logic h, mt, io, sig, psig, cond, dirok;
    logic [3:0] ios;
    h = 1'b0;
    mt = 1'b0;
    io = 1'b0;
    sig = 1'b0;
    psig = 1'b0;
    cond = 1'b0;
    dirok = 1'b0;
    ios = 4'h0;
    lim = 2'b00;
    stp = 2'b00;
    sta = 2'b00;
    hlt = 2'b00;
    ld = 2'b00;
    st_nx[0] = st_q[0];
    st_nx[1] = st_q[1];
    o_set = '0;
    o_clr = '0;
    cap_lo = '0;
    cap_hi = '0;
    dma_any = 1'b0;
    for (int i = 0; i < EST_N_EV; i++) begin
      h = evc_q[i][EST_EVC_HIGH] & ~unify;
      mt = (h ? hit_hi[evc_q[i][EST_EVC_MSEL +: 4]]
              : hit_lo[evc_q[i][EST_EVC_MSEL +: 4]]) & adv[h];
      ev_mt[i] = mt;
      ios = evc_q[i][EST_EVC_IOSEL +: 4];
      sig = evc_q[i][EST_EVC_IOOUT] ? out16[ios] : in16[ios];
      psig = evc_q[i][EST_EVC_IOOUT] ? outp16[ios] : inp16[ios];
      case (evc_q[i][EST_EVC_IOCND +: 2])
        2'h0: io = ~sig;
        2'h1: io = sig & ~psig;
        2'h2: io = ~sig & psig;
        default: io = sig;
      endcase
      case (est_comb_e'(evc_q[i][EST_EVC_COMB +: 2]))
        EST_COMB_OR: cond = mt | io;
        EST_COMB_MATCH: cond = mt;
        EST_COMB_IO: cond = io;
        EST_COMB_AND: cond = (mt | mpend_q[i]) & io;
        default: cond = 1'b0;
      endcase
      case (evc_q[i][EST_EVC_DIRQ +: 2])
        2'h1: dirok = ~bidir[h] | ~dir[h];
        2'h2: dirok = ~bidir[h] | dir[h];
        default: dirok = 1'b1;
      endcase
      ev[i] = cond & dirok & evs_q[i][st_q[h]];
      if (ev[i]) begin
        lim[h] = lim[h] | eva_q[i][EST_EVA_LIM];
        stp[h] = stp[h] | eva_q[i][EST_EVA_STOP];
        sta[h] = sta[h] | eva_q[i][EST_EVA_START];
        hlt[h] = hlt[h] | eva_q[i][EST_EVA_HALT];
        dma_any = dma_any | eva_q[i][EST_EVA_DMA];
        if (evc_q[i][EST_EVC_STLD]) begin
          // Higher numbered events win a state load conflict.
          ld[h] = 1'b1;
          st_nx[h] = evc_q[i][EST_EVC_STV +: EST_SW];
        end
        o_set = o_set | evo_q[i][EST_N_OUT-1:0];
        o_clr = o_clr | evo_q[i][EST_EVO_CLR +: EST_N_OUT];
        if (h) begin
          cap_hi = cap_hi | (eva_q[i][EST_N_MR-1:0] & rmd_q[EST_N_MR-1:0]);
        end else begin
          cap_lo = cap_lo | (eva_q[i][EST_N_MR-1:0] & rmd_q[EST_N_MR-1:0]);
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      // Register zero limits with no event behind it.
      lim[k] = lim[k] | (cfg_q[EST_CFG_ALIM + k]
               & (k == 0 ? hit_lo[0] : hit_hi[0]) & adv[k]);
    end
  end

  // ==========================================================
  // Counter and control
  function automatic logic [32:0] step(input logic [31:0] c,
                                       input logic d, input logic bi,
                                       input logic l);
    logic nd;
    nd = d;
    if (l && !bi) begin
      step = {1'b0, 32'h0};
    end else begin
      if (l) begin
        nd = ~d;
      end else if (bi && d && c == 32'h0) begin
        nd = 1'b0;
      end
      step = {nd, nd ? c - 32'h1 : c + 32'h1};
    end
  endfunction

  logic [32:0] s32, s0, s1;
  logic [31:0] cnt_d;
  logic [1:0] ndir;

  always_comb begin
    s32 = step(cnt_q, dir[0], bidir[0], lim[0]);
    s0 = step({16'h0, cnt_q[15:0]}, dir[0], bidir[0], lim[0]);
    s1 = step({16'h0, cnt_q[31:16]}, dir[1], bidir[1], lim[1]);
    cnt_d = cnt_q;
    ndir = dir;
    if (unify) begin
      if (adv[0]) begin
        cnt_d = s32[31:0];
        ndir[0] = s32[32];
      end
    end else begin
      if (adv[0]) begin
        cnt_d[15:0] = s0[15:0];
        ndir[0] = s0[32];
      end
      if (adv[1]) begin
        cnt_d[31:16] = s1[15:0];
        ndir[1] = s1[32];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= EST_ZERO_RST;
    end else if (clk_en_i) begin
      if (wr_hit(EST_CNT_OFS)) begin
        cnt_q <= merge(cnt_q, wdat, bmask);
      end else if (wr_hit(EST_CTL_OFS)) begin
        cnt_q[15:0] <= (wdat[EST_CTL_CLR] && bmask[EST_CTL_CLR])
                       ? 16'h0 : cnt_d[15:0];
        cnt_q[31:16] <= (wdat[EST_CTL_HI+EST_CTL_CLR]
                         && bmask[EST_CTL_HI+EST_CTL_CLR])
                        ? 16'h0 : cnt_d[31:16];
      end else begin
        cnt_q <= cnt_d;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_q <= EST_CTL_RST;
    end else if (clk_en_i) begin
      logic [31:0] c;
      c = wr_hit(EST_CTL_OFS) ? merge(ctl_q, wdat, bmask) : ctl_q;
      for (int h = 0; h < 2; h++) begin
        c[h*EST_CTL_HI + EST_CTL_CLR] = 1'b0;
        c[h*EST_CTL_HI + EST_CTL_DOWN] = ndir[h];
        // Event requests override a software write in the same cycle.
        if (sta[h]) begin
          c[h*EST_CTL_HI + EST_CTL_STOP] = 1'b0;
        end
        if (stp[h]) begin
          c[h*EST_CTL_HI + EST_CTL_STOP] = 1'b1;
        end
        if (hlt[h]) begin
          c[h*EST_CTL_HI + EST_CTL_HALT] = 1'b1;
        end
      end
      ctl_q <= c;
    end
  end

  // ==========================================================
  // State variables, hold flags, match and capture registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q[0] <= '0;
      st_q[1] <= '0;
    end else if (clk_en_i) begin
      // Limits and wraps leave the state untouched.
      for (int h = 0; h < 2; h++) begin
        if (ld[h]) begin
          st_q[h] <= st_nx[h];
        end else if (wr_hit(EST_STA_OFS)) begin
          st_q[h] <= wdat[h*16 +: EST_SW];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mpend_q <= '0;
    end else if (clk_en_i) begin
      for (int i = 0; i < EST_N_EV; i++) begin
        if (ev[i]) begin
          mpend_q[i] <= 1'b0;
        end else if (ev_mt[i] && evc_q[i][EST_EVC_MHOLD]) begin
          mpend_q[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int j = 0; j < EST_N_MR; j++) begin
        mr_q[j] <= EST_ZERO_RST;
      end
    end else if (clk_en_i) begin
      for (int j = 0; j < EST_N_MR; j++) begin
        if (cap_lo[j] && unify) begin
          mr_q[j] <= cnt_q;
        end else if (cap_lo[j] || cap_hi[j]) begin
          if (cap_lo[j]) begin
            mr_q[j][15:0] <= cnt_q[15:0];
          end
          if (cap_hi[j]) begin
            mr_q[j][31:16] <= cnt_q[31:16];
          end
        end else if (wr_acc && is_mr && mr_idx == j[3:0]) begin
          mr_q[j] <= merge(mr_q[j], wdat, bmask);
        end
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= EST_ZERO_RST;
      ien_q <= EST_ZERO_RST;
      rmd_q <= EST_ZERO_RST;
      cfl_q <= EST_ZERO_RST;
      for (int i = 0; i < EST_N_EV; i++) begin
        evs_q[i] <= EST_ZERO_RST;
        evc_q[i] <= EST_ZERO_RST;
        evo_q[i] <= EST_ZERO_RST;
        eva_q[i] <= EST_ZERO_RST;
      end
    end else if (clk_en_i) begin
      if (wr_hit(EST_CFG_OFS)) cfg_q <= merge(cfg_q, wdat, bmask);
      if (wr_hit(EST_IEN_OFS)) ien_q <= merge(ien_q, wdat, bmask);
      if (wr_hit(EST_RMD_OFS)) rmd_q <= merge(rmd_q, wdat, bmask);
      if (wr_hit(EST_CFL_OFS)) cfl_q <= merge(cfl_q, wdat, bmask);
      if (wr_acc && is_ev) begin
        case (ev_sub)
          2'h0: evs_q[ev_idx] <= merge(evs_q[ev_idx], wdat, bmask);
          2'h1: evc_q[ev_idx] <= merge(evc_q[ev_idx], wdat, bmask);
          2'h2: evo_q[ev_idx] <= merge(evo_q[ev_idx], wdat, bmask);
          default: eva_q[ev_idx] <= merge(eva_q[ev_idx], wdat, bmask);
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs, flags and requests
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_q <= '0;
      out_prev_q <= '0;
      in_prev_q <= '0;
    end else if (clk_en_i) begin
      in_prev_q <= ev_in_i;
      out_prev_q <= out_q;
      for (int o = 0; o < EST_N_OUT; o++) begin
        // PWM edges come from match events; register zero sets the period.
        if (o_set[o] && o_clr[o]) begin
          case (cfl_q[2*o +: 2])
            2'h1: out_q[o] <= 1'b1;
            2'h2: out_q[o] <= 1'b0;
            2'h3: out_q[o] <= ~out_q[o];
            default: out_q[o] <= out_q[o];
          endcase
        end else if (o_set[o]) begin
          out_q[o] <= 1'b1;
        end else if (o_clr[o]) begin
          out_q[o] <= 1'b0;
        end else if (wr_hit(EST_OUT_OFS) && bmask[o]) begin
          out_q[o] <= wdat[o];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= EST_ZERO_RST;
      irq_q <= 1'b0;
      dma_q <= 1'b0;
    end else if (clk_en_i) begin
      // A new event wins over a write-one-to-clear in the same cycle.
      flag_q[EST_N_EV-1:0] <= (flag_q[EST_N_EV-1:0]
        & ~(wr_hit(EST_FLG_OFS) ? wdat[EST_N_EV-1:0] & bmask[EST_N_EV-1:0]
                                : '0)) | ev;
      irq_q <= |(flag_q[EST_N_EV-1:0] & ien_q[EST_N_EV-1:0]);
      dma_q <= dma_any;
    end
  end

  // ==========================================================
  // Bus slave: one wait cycle, then the answer
  logic [31:0] rd;

  always_comb begin
    rd = 32'h0;
    case (adr)
      EST_CFG_OFS: rd = cfg_q;
      EST_CTL_OFS: rd = ctl_q;
      EST_CNT_OFS: rd = cnt_q;
      EST_STA_OFS: rd = {11'h0, st_q[1], 11'h0, st_q[0]};
      EST_INP_OFS: rd = {{(32-EST_N_IN){1'b0}}, ev_in_i};
      EST_OUT_OFS: rd = {{(32-EST_N_OUT){1'b0}}, out_q};
      EST_FLG_OFS: rd = flag_q;
      EST_IEN_OFS: rd = ien_q;
      EST_RMD_OFS: rd = rmd_q;
      EST_CFL_OFS: rd = cfl_q;
      default: begin
        if (is_ev) begin
          case (ev_sub)
            2'h0: rd = evs_q[ev_idx];
            2'h1: rd = evc_q[ev_idx];
            2'h2: rd = evo_q[ev_idx];
            default: rd = eva_q[ev_idx];
          endcase
        end else if (is_mr) begin
          rd = mr_q[mr_idx];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_q.waitrequest <= 1'b1;
      rsp_q.readdata <= EST_ZERO_RST;
    end else if (clk_en_i) begin
      if (rsp_q.waitrequest && (av_req_i.read || av_req_i.write)) begin
        rsp_q.waitrequest <= 1'b0;
        rsp_q.readdata <= av_req_i.read ? rd : 32'h0;
      end else begin
        rsp_q.waitrequest <= 1'b1;
      end
    end
  end
endmodule // est_core

// ===== dv/est_core_sva.sv
// Port-level concurrent checks for the event state timer core.
`timescale 1ns/10ps
module est_core_sva
  import est_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input est_pkg::est_av_req_s av_req_i,
  input est_pkg::est_av_rsp_s av_rsp_o,
  input wire logic [est_pkg::EST_N_IN-1:0] ev_in_i,
  input wire logic [est_pkg::EST_N_OUT-1:0] ev_out_o,
  input wire logic irq_o,
  input wire logic dma_req_o
);
  // ==========================================================
  // Helpers
  logic wrote_q;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Until software completes a write nothing is configured to act.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wrote_q <= 1'b0;
    end else if (clk_en_i && av_req_i.write && !av_rsp_o.waitrequest) begin
      wrote_q <= 1'b1;
    end
  end
  sequence s_seen;
    (av_req_i.read || av_req_i.write) && av_rsp_o.waitrequest && clk_en_i;
  endsequence
  sequence s_gap_read;
    av_req_i.read && av_rsp_o.waitrequest && clk_en_i &&
      av_req_i.address inside {[12'h028:12'h0fc]} ##1 !av_rsp_o.waitrequest;
  endsequence
  // ==========================================================
  // Assertions
  AST_ANSWER: assert property (s_seen |=> !av_rsp_o.waitrequest)
    else $error("bus request not answered after one cycle");
  AST_RELEASE: assert property (
    !av_rsp_o.waitrequest && clk_en_i |=> av_rsp_o.waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_IDLE: assert property (
    !av_req_i.read && !av_req_i.write && av_rsp_o.waitrequest
    |=> av_rsp_o.waitrequest)
    else $error("answer given without a request");
  AST_RDHOLD: assert property (
    av_rsp_o.waitrequest ##1 av_rsp_o.waitrequest
    |-> $stable(av_rsp_o.readdata))
    else $error("read data changed between answers");
  AST_FREEZE: assert property (
    !clk_en_i |=> $stable(ev_out_o) && $stable(irq_o) && $stable(av_rsp_o))
    else $error("state moved while clock enable was low");
  AST_RESET_VAL: assert property (
    $rose(rst_b_i) |-> av_rsp_o.waitrequest && !irq_o && !dma_req_o
      && ev_out_o == '0)
    else $error("outputs not at reset values after release");
  AST_UNMAPPED: assert property (
    s_gap_read |-> av_rsp_o.readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  AST_QUIET: assert property (
    !wrote_q |-> !irq_o && !dma_req_o && ev_out_o == '0)
    else $error("activity before any configuration");
endmodule // est_core_sva

bind est_core est_core_sva u_sva (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i),
  .av_req_i(av_req_i),
  .av_rsp_o(av_rsp_o),
  .ev_in_i(ev_in_i),
  .ev_out_o(ev_out_o),
  .irq_o(irq_o),
  .dma_req_o(dma_req_o)
);

// ===== dv/test_event_state_timer_pwm.sv
// Directed register-level testbench for the event state timer core.
`timescale 1ns/10ps
module test_event_state_timer_pwm;
  import est_pkg::*;
  logic core_clk_i;
  logic rst_b_i;
  logic clk_en_i;
  est_av_req_s req;
  est_av_rsp_s rsp;
  logic [EST_N_IN-1:0] ev_in;
  logic [EST_N_OUT-1:0] ev_out;
  logic irq;
  logic dma;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int dma_seen = 0;
  logic [31:0] a;
  logic [31:0] b;

  est_core dut (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .av_req_i(req),
    .av_rsp_o(rsp),
    .ev_in_i(ev_in),
    .ev_out_o(ev_out),
    .irq_o(irq),
    .dma_req_o(dma)
  );

  // ==========================================================
  // Clock, timeout and monitors
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (dma === 1'b1 && clk_en_i === 1'b1) begin
      dma_seen++;
    end
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low, then lets an edge
  // pass so read or write is never lowered and raised in one step.
  task automatic bus(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    req.read <= !w;
    req.write <= w;
    req.address <= ad;
    req.writedata <= d;
    // Only the bench timeout ends a wait that never gets an answer.
    do begin
      @(posedge core_clk_i);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    chk(q, e);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    req = '0;
    req.byteenable = 4'hf;
    clk_en_i = 1'b1;
    ev_in = '0;
    rst_b_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(EST_CTL_OFS, EST_CTL_RST);
    rd(EST_CNT_OFS, EST_ZERO_RST);
    rd(EST_FLG_OFS, EST_ZERO_RST);
    wr(EST_OUT_OFS, 32'h2a4);
    chk({22'h0, ev_out}, 32'h2a4);
    wr(12'h0fc, 32'hffff_ffff);
    rd(12'h0fc, 32'h0);
    // Two reads of a free-running count are three cycles apart.
    wr(EST_CFG_OFS, 32'h1);
    wr(EST_CTL_OFS, 32'h10);
    bus(1'b0, EST_CNT_OFS, 32'h0, a);
    bus(1'b0, EST_CNT_OFS, 32'h0, b);
    chk(b - a, 32'h3);
    // Event 0: match on register 0, set output 0, capture, state, DMA.
    // The condition goes in before the state mask: the all-zero condition
    // is a level match on a low input and would fire at once.
    wr(EST_CTL_OFS, 32'h12);
    wr(12'h200, 32'h3);
    wr(EST_RMD_OFS, 32'h2);
    wr(12'h104, 32'h15000);
    wr(12'h100, 32'h1);
    wr(12'h108, 32'h1);
    wr(12'h10c, 32'h10_0002);
    wr(EST_IEN_OFS, 32'h1);
    wr(EST_CTL_OFS, 32'h10);
    for (int n = 0; n < 50 && irq !== 1'b1; n++) begin
      @(posedge core_clk_i);
    end
    chk({22'h0, ev_out}, 32'h2a5);
    chk({31'h0, irq}, 32'h1);
    chk(dma_seen, 32'h1);
    rd(EST_FLG_OFS, 32'h1);
    rd(EST_STA_OFS, 32'h2);
    rd(12'h204, 32'h3);
    wr(EST_IEN_OFS, 32'h0);
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(EST_IEN_OFS, 32'h1);
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(EST_FLG_OFS, 32'h1);
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0);
    // Automatic limit on register 0 keeps the count within 0..5.
    wr(EST_CTL_OFS, 32'h12);
    wr(EST_CFG_OFS, 32'h21);
    wr(12'h200, 32'h5);
    wr(EST_CTL_OFS, 32'h0);
    clk_en_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      bus(1'b0, EST_CNT_OFS, 32'h0, a);
      chk({31'h0, a <= 32'h5}, 32'h1);
    end
    rd(EST_STA_OFS, 32'h2);
    // Input clocking: four rising edges on input 0 give a count of four.
    wr(EST_CTL_OFS, 32'h12);
    wr(EST_CFG_OFS, 32'h3);
    wr(EST_CTL_OFS, 32'h0);
    for (int n = 0; n < 4; n++) begin
      ev_in <= 8'h01;
      @(posedge core_clk_i);
      ev_in <= 8'h00;
      @(posedge core_clk_i);
    end
    rd(EST_CNT_OFS, 32'h4);
    give_verdict();
  end
endmodule // test_event_state_timer_pwm
